// >>> verilog/crc_cfg.svh
// Purpose: Offsets, field positions and reset values of the checksum generator
// Assumes: 32-bit register words on a 12-bit byte address
// Notes: Definitions only
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define CRC_ADDR_W 12
`define CRC_OFS_CTRL 12'h000
`define CRC_OFS_VALUE 12'h004
`define CRC_OFS_XOR 12'h008
`define CRC_OFS_COUNT 12'h00C

// ==========================================================
// Control field positions
`define CRC_TYPE_BIT 15
`define CRC_POLY_LEN_LSB 8
`define CRC_POLY_LEN_W 5
`define CRC_EN_BIT 7

// ==========================================================
// Widths, reset values and responses
`define CRC_WORD_W 32
`define CRC_HALF_W 16
`define CRC_RESET_WORD 32'h0000_0000
`define CRC_RESET_POLY_LEN 5'h1F
`define CRC_RESP_OKAY 2'h0
`define CRC_RESP_SLVERR 2'h2

`endif

// >>> verilog/crc_pkg.sv
// Purpose: Types and shared arithmetic of the checksum generator
// Assumes: crc_cfg.svh defines the widths
// Notes: Functions are used by the engine and by the register logic and checks in the top
`include "crc_cfg.svh"
package crc_pkg;

    typedef enum logic {lfsr_mode, ip_mode} crc_mode_type;

    typedef struct packed {
        logic checksum_type_select;
        logic [`CRC_POLY_LEN_W-1:0] polynomial_length;
        logic enable;
    } crc_ctrl_type;

    typedef struct packed {
        logic [`CRC_ADDR_W-1:0] addr;
        logic [`CRC_WORD_W-1:0] data;
        logic [3:0] strb;
    } reg_write_type;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(logic [31:0] old_w, logic [31:0] new_w,
        logic [3:0] strb);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                m[i*8 +: 8] = new_w[i*8 +: 8];
        return m;
    endfunction

    // Ones-complement add with end-around carry
    function automatic logic [15:0] ones_add(logic [15:0] a, logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0, s[16]};
    endfunction

    // One word through the LFSR, most significant data bit first
    function automatic logic [31:0] lfsr_word(logic [31:0] crc, logic [31:0] xe,
        logic [31:0] data, logic [4:0] len);
        logic [31:0] c;
        logic fb;
        c = crc;
        for (int b = 31; b >= 0; b--)
        begin
            fb = c[len] ^ data[b];
            for (int i = 31; i > 0; i--)
                c[i] = c[i-1] ^ (xe[i] & fb);
            c[0] = fb;
        end
        return c;
    endfunction

endpackage

// >>> verilog/crc_engine.sv
// Purpose: Checksum datapath, LFSR CRC or ones-complement header sum
// Assumes: Seed load is a single-cycle pulse; step is high one cycle per word, back to back for consecutive words
// Notes: Raw state is kept; read shaping is combinational
`timescale 1ns/100ps
`default_nettype none
`include "crc_cfg.svh"
module crc_engine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire crc_pkg::crc_mode_type mode,
    input wire logic [`CRC_POLY_LEN_W-1:0] poly_len,
    input wire logic [31:0] xor_en,
    input wire logic seed_load,
    input wire logic [31:0] seed,
    input wire logic step,
    input wire logic [31:0] word,
    output logic [31:0] raw,
    output logic [31:0] read_value
);
    logic [31:0] raw_q;
    logic [31:0] raw_d;
    logic [31:0] len_mask;
    logic [15:0] ip_sum;

    // ==========================================================
    // Per-bit length mask, bits above the length read zero
    for (genvar i = 0; i < `CRC_WORD_W; i++)
    begin : g_mask
        assign len_mask[i] = (5'(i) <= poly_len);
    end

    // Header sum folds both halves of the word
    assign ip_sum = crc_pkg::ones_add(crc_pkg::ones_add(raw_q[15:0], word[31:16]),
        word[15:0]);

    // Seed wins over a data step in the same cycle
    assign raw_d = seed_load ? ((mode == crc_pkg::ip_mode) ?
            {16'h0000, ~seed[15:0]} : seed) :  // see R1, see R6
        !step ? raw_q :
        (mode == crc_pkg::ip_mode) ? {16'h0000, ip_sum} :  // see R7
        crc_pkg::lfsr_word(raw_q, xor_en, word, poly_len);  // see R8

    // Read view: header mode complements low half, LFSR masks length
    assign read_value = (mode == crc_pkg::ip_mode) ?
        {16'h0000, ~raw_q[15:0]} :  // see R5, see R6
        (raw_q & len_mask);  // see R3
    assign raw = raw_q;

    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            raw_q <= `CRC_RESET_WORD;
        else
            raw_q <= raw_d;
    end
endmodule
`default_nettype wire

// >>> verilog/crc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the checksum registers
// Assumes: One write and one read in flight at a time
// Notes: Address and data are taken in either order; unmapped gets SLVERR
`timescale 1ns/100ps
`default_nettype none
`include "crc_cfg.svh"
module crc_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`CRC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`CRC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output crc_pkg::reg_write_type wr,
    output logic wr_en,
    output logic [`CRC_ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data
);
    logic have_aw_q, have_w_q, rpend_q;
    logic aw_take, w_take, ar_take, commit, wr_ok, rd_ok;

    // ==========================================================
    // Handshakes and address decode
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign ar_take = arvalid && arready;
    assign commit = have_aw_q && have_w_q && !bvalid;
    assign wr_ok = wr.addr == `CRC_OFS_CTRL || wr.addr == `CRC_OFS_VALUE ||
        wr.addr == `CRC_OFS_XOR || wr.addr == `CRC_OFS_COUNT;
    assign rd_ok = rd_addr == `CRC_OFS_CTRL || rd_addr == `CRC_OFS_VALUE ||
        rd_addr == `CRC_OFS_XOR || rd_addr == `CRC_OFS_COUNT;

    // Write channel: hold each half until both are in, then answer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `CRC_RESP_OKAY;
            wr <= '0;
            wr_en <= 1'b0;
        end
        else
        begin
            have_aw_q <= (have_aw_q || aw_take) && !commit;
            have_w_q <= (have_w_q || w_take) && !commit;
            awready <= !(have_aw_q || aw_take) || commit;
            wready <= !(have_w_q || w_take) || commit;
            if (aw_take)
                wr.addr <= awaddr;
            if (w_take)
            begin
                wr.data <= wdata;
                wr.strb <= wstrb;
            end
            wr_en <= commit && wr_ok;
            if (commit)
                bresp <= wr_ok ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
            bvalid <= commit || (bvalid && !bready);
        end
    end

    // Read channel: latch address, answer one cycle later
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rpend_q <= 1'b0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= `CRC_RESET_WORD;
            rresp <= `CRC_RESP_OKAY;
            rd_addr <= '0;
        end
        else
        begin
            if (ar_take)
                rd_addr <= araddr;
            rpend_q <= ar_take;
            if (rpend_q)
            begin
                rdata <= rd_ok ? rd_data : `CRC_RESET_WORD;
                rresp <= rd_ok ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
            end
            rvalid <= rpend_q || (rvalid && !rready);
            arready <= !ar_take && !rpend_q && !(rvalid && !rready);
        end
    end
endmodule
`default_nettype wire

// >>> verilog/dma_crc_generator.sv
// Purpose: DMA-attached checksum generator with AXI4-Lite registers
// Assumes: DMA words arrive on a valid/ready port in the aclk domain
// Notes: Value reads have no side effect; seed writes restart the count
`timescale 1ns/100ps
`default_nettype none
`include "crc_cfg.svh"
// Summary of operation
// R1 - Writing the value register loads it as the new seed.
// R2 - Reading the value register returns the present result, changing nothing.
// R3 - In LFSR mode, value bits above the polynomial length read zero.
// R4 - Type select 1 selects header checksum mode, 0 selects LFSR mode.
// R5 - In header mode only the low 16 bits carry data; upper read zero.
// R6 - In header mode writes and reads use ones-complement form.
// R7 - In header mode the feedback-enable register has no effect.
// R8 - LFSR stages 1-31 with enable 1 take XOR feedback, else the previous stage; stage 0 always takes the feedback.
// R9 - Each DMA word taken while enabled advances the checksum; a word taken in the same cycle as a value write is dropped.
module dma_crc_generator #(
    parameter int ADDR_W = `CRC_ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dma_valid,
    input wire logic [31:0] dma_word,
    output logic dma_ready
);
    crc_pkg::crc_ctrl_type ctrl_q;
    crc_pkg::crc_ctrl_type ctrl_d;
    crc_pkg::crc_mode_type mode;
    crc_pkg::reg_write_type wr;
    logic wr_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic [31:0] xor_q;
    logic [31:0] count_q;
    logic [31:0] ctrl_word;
    logic [31:0] raw;
    logic [31:0] read_value;
    logic [31:0] ctrl_new;
    logic [31:0] seed;
    logic wr_ctrl, wr_value, wr_xor, dma_take;

    // ==========================================================
    // Bus slave
    crc_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr(wr),
        .wr_en(wr_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ==========================================================
    // Write decode; the count register is read-only
    assign wr_ctrl = wr_en && wr.addr == `CRC_OFS_CTRL;
    assign wr_value = wr_en && wr.addr == `CRC_OFS_VALUE;
    assign wr_xor = wr_en && wr.addr == `CRC_OFS_XOR;

    // Control word as software sees it, unused bits zero
    assign ctrl_word = ({31'h0, ctrl_q.checksum_type_select} << `CRC_TYPE_BIT) |
        ({27'h0, ctrl_q.polynomial_length} << `CRC_POLY_LEN_LSB) |
        ({31'h0, ctrl_q.enable} << `CRC_EN_BIT);
    assign ctrl_new = crc_pkg::lane_merge(ctrl_word, wr.data, wr.strb);
    assign ctrl_d.checksum_type_select = ctrl_new[`CRC_TYPE_BIT];
    assign ctrl_d.polynomial_length = ctrl_new[`CRC_POLY_LEN_LSB +: `CRC_POLY_LEN_W];
    assign ctrl_d.enable = ctrl_new[`CRC_EN_BIT];

    // Mode follows the type select bit directly
    assign mode = ctrl_q.checksum_type_select ? crc_pkg::ip_mode :
        crc_pkg::lfsr_mode;  // see R4

    // Partial seed writes keep the unwritten lanes of the visible value
    assign seed = crc_pkg::lane_merge(read_value, wr.data, wr.strb);  // see R1

    // A word moves only while the ready flop is high
    assign dma_take = dma_valid && dma_ready;  // see R9

    // Read mux; pure selection so a read never disturbs the state
    assign rd_data = (rd_addr == `CRC_OFS_CTRL) ? ctrl_word :
        (rd_addr == `CRC_OFS_VALUE) ? read_value :  // see R2
        (rd_addr == `CRC_OFS_XOR) ? xor_q :
        (rd_addr == `CRC_OFS_COUNT) ? count_q : `CRC_RESET_WORD;

    // ==========================================================
    // Datapath
    crc_engine u_engine (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode(mode),
        .poly_len(ctrl_q.polynomial_length),
        .xor_en(xor_q),
        .seed_load(wr_value),
        .seed(seed),
        .step(dma_take),
        .word(dma_word),
        .raw(raw),
        .read_value(read_value)
    );

    // ==========================================================
    // Control and feedback-enable registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= '0;
            xor_q <= `CRC_RESET_WORD;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= ctrl_d;
            if (wr_xor)
                xor_q <= crc_pkg::lane_merge(xor_q, wr.data, wr.strb);
        end
    end

    // Ready is a flop so it changes one cycle after the enable bit;
    // a word still in flight at disable is taken on that last cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dma_ready <= 1'b0;
        else
            dma_ready <= ctrl_q.enable;  // see R9
    end

    // Words folded since the last seed; the seed restarts the count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_q <= `CRC_RESET_WORD;
        else if (wr_value)
            count_q <= `CRC_RESET_WORD;
        else if (dma_take)
            count_q <= count_q + 32'h0000_0001;
    end

    // ==========================================================
    // Checks
    logic [31:0] len_mask_chk;
    always_comb
    begin
        len_mask_chk = '0;
        for (int i = 0; i < `CRC_WORD_W; i++)
            len_mask_chk[i] = (5'(i) <= ctrl_q.polynomial_length);
    end

    // Full-word seed in LFSR mode lands unchanged in the raw state
    a_seed_load: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
        wr_value && wr.strb == 4'hF && mode == crc_pkg::lfsr_mode |=> raw == $past(wr.data))
        else $error("seed write did not load the value");

    // A value read with no write and no word leaves the state alone
    a_read_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
        s_axi_arvalid && s_axi_arready && !wr_en && !dma_take ##1 !wr_en && !dma_take
        |=> $stable(read_value))
        else $error("read disturbed the checksum");

    // Read data of the value register matches the visible value
    a_read_data: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `CRC_OFS_VALUE && !wr_en && !dma_take
        ##1 !wr_en && !dma_take |=> s_axi_rvalid && s_axi_rdata == $past(read_value, 2))
        else $error("value read returned wrong data");

    // LFSR mode: nothing above the polynomial length
    a_len_mask: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
        mode == crc_pkg::lfsr_mode |-> (read_value & ~len_mask_chk) == 32'h0000_0000)
        else $error("bits above length not zero");

    // Mode follows the type select bit
    a_mode_select: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
        (mode == crc_pkg::ip_mode) == ctrl_q.checksum_type_select)
        else $error("mode does not follow type select");

    // Header mode: upper half always zero
    a_ip_upper: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
        mode == crc_pkg::ip_mode |-> read_value[31:16] == 16'h0000)
        else $error("header mode upper half not zero");

    // Header mode: a full seed reads back unchanged through the complement
    a_ip_form: assert property (@(posedge aclk) disable iff (!aresetn) // see R6
        wr_value && wr.strb == 4'hF && mode == crc_pkg::ip_mode |=>
        raw[15:0] == ~$past(wr.data[15:0]) && read_value[15:0] == $past(wr.data[15:0]))
        else $error("header seed not held in complement form");

    // Header mode: one word adds both halves, feedback enables unused
    a_ip_step: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
        dma_take && !wr_value && mode == crc_pkg::ip_mode |=> raw[15:0] ==
        crc_pkg::ones_add(crc_pkg::ones_add($past(raw[15:0]), $past(dma_word[31:16])),
        $past(dma_word[15:0])))
        else $error("header sum step wrong");

    // LFSR mode with no enables is a plain shift of data through stages
    a_lfsr_shift: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
        dma_take && !wr_value && mode == crc_pkg::lfsr_mode && xor_q == 32'h0000_0000 &&
        ctrl_q.polynomial_length == 5'h1F |=> raw == ($past(raw) ^ $past(dma_word)))
        else $error("stage without enable did not shift");

    // Ready follows the enable bit one cycle later
    a_ready_enable: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
        ##1 dma_ready == $past(ctrl_q.enable))
        else $error("dma ready does not follow enable");

    // Each word taken outside a seed write advances the count by one
    a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
        dma_take && !wr_value |=> count_q == $past(count_q) + 32'h0000_0001)
        else $error("word not counted");

    c_lfsr_word: cover property (@(posedge aclk) disable iff (!aresetn)
        dma_take && mode == crc_pkg::lfsr_mode && xor_q != 32'h0000_0000);
    c_ip_word: cover property (@(posedge aclk) disable iff (!aresetn)
        dma_take && mode == crc_pkg::ip_mode);
    c_seed_during_word: cover property (@(posedge aclk) disable iff (!aresetn)
        dma_take && wr_value);
    c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bresp == `CRC_RESP_SLVERR);
endmodule
`default_nettype wire

// >>> verif/dma_source_model.sv
// Purpose: DMA channel model that offers words to the checksum generator
// Assumes: A word is taken at an edge where valid and ready are both high
// Notes: Idle data lines toggle so a stale word is never seen as fresh
`timescale 1ns/100ps
`default_nettype none
module dma_source_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dma_ready,
    output logic dma_valid = 1'b0,
    output logic [31:0] dma_word = 32'h0
);
    logic [31:0] q[$];
    int gap = 0;
    int idle = 0;
    // ==========================================================
    // Offer
    // Word and valid are held until taken; gap makes a slow channel
    always @(posedge aclk)
    begin
        if (!aresetn)
            dma_valid <= 1'b0;
        else if (!dma_valid || dma_ready)
        begin
            if (idle < gap || q.size() == 0)
            begin
                dma_valid <= 1'b0;
                dma_word <= ~dma_word;
                idle++;
            end
            else
            begin
                dma_valid <= 1'b1;
                dma_word <= q.pop_front();
                idle = 0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/dma_crc_generator_tb.sv
// Purpose: Self-checking bench for the DMA checksum generator
// Assumes: Register offsets and control fields from crc_cfg.svh
// Notes: Expected sums come from bench-side reference functions
`timescale 1ns/100ps
`default_nettype none
`include "crc_cfg.svh"
module dma_crc_generator_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, dma_valid, dma_ready;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd, dma_word;
    logic [31:0] words [4] = '{32'h4500_0073, 32'h0000_4000, 32'h4011_C0A8, 32'hFFFF_0001};
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2.5 aclk = ~aclk;

    dma_crc_generator dma_crc_generator_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dma_valid(dma_valid),
        .dma_word(dma_word), .dma_ready(dma_ready));
    dma_source_model dma_source_model_inst (.aclk(aclk), .aresetn(aresetn),
        .dma_ready(dma_ready), .dma_valid(dma_valid), .dma_word(dma_word));

    // ==========================================================
    // Reporting
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Watchdog; the whole run needs well under a thousand cycles
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            end_sim();
        end
    end

    // ==========================================================
    // Bus cycles
    // Both channels are offered together and each is dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (awvalid || wvalid || !bvalid)
        begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            @(posedge aclk);
        end
        bready <= 1'b0;
        resp = bresp;
    endtask

    task automatic rd_reg(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arvalid || !rvalid)
        begin
            if (arready) arvalid <= 1'b0;
            @(posedge aclk);
        end
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd_reg(a);
        chk(rd, exp);
        chk({30'h0, resp}, {30'h0, `CRC_RESP_OKAY});
    endtask

    // Waits until the model has handed over every queued word
    task automatic drain();
        do @(posedge aclk);
        while (dma_source_model_inst.q.size() != 0 || dma_valid);
    endtask

    // ==========================================================
    // Reference arithmetic, bit 31 of each word first
    function automatic logic [31:0] lfsr_ref(logic [31:0] c, logic [31:0] x,
        logic [31:0] d, int n);
        logic f;
        for (int b = 31; b >= 0; b--)
        begin
            f = c[n] ^ d[b];
            c = (c << 1) ^ ({x[31:1], 1'b0} & {32{f}});
            c[0] = f;
        end
        return c;
    endfunction

    function automatic logic [15:0] oadd(logic [15:0] a, logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + 16'(s[16]);
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rchk(`CRC_OFS_CTRL, 32'h0);
        rchk(`CRC_OFS_VALUE, 32'h0);
        rchk(`CRC_OFS_XOR, 32'h0);
        chk({31'h0, dma_ready}, 32'h0);
        rd_reg(12'h010);
        chk(rd, 32'h0);
        chk({30'h0, resp}, {30'h0, `CRC_RESP_SLVERR});
        wr(12'h010, 32'hFFFF_FFFF);
        chk({30'h0, resp}, {30'h0, `CRC_RESP_SLVERR});
    endtask

    // A word offered while disabled must wait until the function is enabled
    task automatic t_off();
        wr(`CRC_OFS_CTRL, 32'h0000_1F00);
        wr(`CRC_OFS_XOR, 32'h04C1_1DB7);
        wr(`CRC_OFS_VALUE, 32'h1234_5678);
        dma_source_model_inst.q.push_back(words[2]);
        repeat (6) @(posedge aclk);
        chk({31'h0, dma_ready}, 32'h0);
        rchk(`CRC_OFS_VALUE, 32'h1234_5678);
        wr(`CRC_OFS_CTRL, 32'h0000_1F80);
        drain();
        rchk(`CRC_OFS_VALUE, lfsr_ref(32'h1234_5678, 32'h04C1_1DB7, words[2], 31));
    endtask

    task automatic t_lfsr(input int n, input logic [31:0] x, input logic [31:0] seed,
        input int gap);
        logic [31:0] m, e;
        m = 32'((64'h1 << (n + 1)) - 64'h1);
        e = seed;
        wr(`CRC_OFS_CTRL, (32'(n) << `CRC_POLY_LEN_LSB) | 32'h80);
        wr(`CRC_OFS_XOR, x);
        rchk(`CRC_OFS_XOR, x);
        wr(`CRC_OFS_VALUE, seed);
        chk({30'h0, resp}, {30'h0, `CRC_RESP_OKAY});
        rchk(`CRC_OFS_VALUE, seed & m);
        dma_source_model_inst.gap = gap;
        for (int i = 0; i < 4; i++)
        begin
            dma_source_model_inst.q.push_back(words[i]);
            e = lfsr_ref(e, x, words[i], n);
        end
        drain();
        rchk(`CRC_OFS_VALUE, e & m);
        rchk(`CRC_OFS_VALUE, e & m);
        rchk(`CRC_OFS_COUNT, 32'h0000_0004);
    endtask

    task automatic t_ip(input logic [31:0] x, input logic [31:0] seed);
        logic [15:0] s;
        s = ~seed[15:0];
        wr(`CRC_OFS_CTRL, 32'h0000_8080);
        wr(`CRC_OFS_XOR, x);
        wr(`CRC_OFS_VALUE, seed);
        rchk(`CRC_OFS_VALUE, {16'h0, seed[15:0]});
        for (int i = 0; i < 4; i++)
        begin
            dma_source_model_inst.q.push_back(words[i]);
            s = oadd(oadd(s, words[i][31:16]), words[i][15:0]);
        end
        drain();
        rchk(`CRC_OFS_VALUE, {16'h0, ~s});
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_off();
        t_lfsr(15, 32'h0000_8005, 32'h0000_FFFF, 0);
        t_lfsr(31, 32'h04C1_1DB7, 32'hFFFF_FFFF, 2);
        t_lfsr(4, 32'h0000_0015, 32'hFFFF_FFFF, 1);
        t_lfsr(0, 32'h0000_0000, 32'h0000_0003, 0);
        t_lfsr(31, 32'h0000_0000, 32'hA5A5_0F0F, 0);
        t_ip(32'h0000_0000, 32'h1234_ABCD);
        t_ip(32'hFFFF_FFFF, 32'h1234_ABCD);
        end_sim();
    end
endmodule
`default_nettype wire
